/* File: hw/sea_cell_array.sv */
`timescale 1ns/1ps
`default_nettype none
module sea_cell_array
    import sea_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF,
    parameter int          WORDS       = NUM_WORDS
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_start,
    input  wire sea_cmd_t          i_cmd,
    input  wire logic              i_org,
    input  wire logic              i_rd_load,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_busy
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    logic [DATA_W-1:0] mem_r [WORDS];
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  run_len_r;

    // even byte address is the high half of a word
    function automatic logic [7:0] byte_of(input logic [15:0] w, input logic lo);
        return lo ? w[7:0] : w[15:8];
    endfunction : byte_of

    // ==========================================================
    // cell updates
    // contents change at cycle start; busy covers the whole timed window
    always_ff @(posedge i_core_clk) begin
        if (i_start) begin
            unique case (i_cmd.op)
                OP_WRITE: begin
                    if (i_org) mem_r[i_cmd.addr[3:0]] <= i_cmd.data;
                    else if (i_cmd.addr[0]) mem_r[i_cmd.addr[4:1]][7:0] <= i_cmd.data[7:0];
                    else mem_r[i_cmd.addr[4:1]][15:8] <= i_cmd.data[7:0];
                end
                OP_ERASE: begin
                    if (i_org) mem_r[i_cmd.addr[3:0]] <= ERASED_WORD;
                    else if (i_cmd.addr[0]) mem_r[i_cmd.addr[4:1]][7:0] <= ERASED_WORD[7:0];
                    else mem_r[i_cmd.addr[4:1]][15:8] <= ERASED_WORD[7:0];
                end
                OP_ERASE_ALL: begin
                    for (int i = 0; i < WORDS; i++) mem_r[i] <= ERASED_WORD;
                end
                OP_FILL_ALL: begin
                    for (int i = 0; i < WORDS; i++) begin
                        mem_r[i] <= i_org ? i_cmd.data : {i_cmd.data[7:0], i_cmd.data[7:0]};
                    end
                end
                OP_READ, OP_UNLOCK, OP_LOCK: begin
                end
            endcase
        end
    end

    // ==========================================================
    // self-timed cycle
    // internal timer
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            cnt_r  <= '0;
        end else if (i_start) begin
            o_busy <= 1'b1;
            cnt_r  <= CNT_W'(PROG_CYCLES - 1);
        end else if (o_busy) begin
            if (cnt_r == '0) o_busy <= 1'b0;
            else cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) run_len_r <= '0;
        else if (o_busy) run_len_r <= run_len_r + CNT_W'(1);
        else run_len_r <= '0;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) o_rd_data <= '0;
        else if (i_rd_load) begin
            if (i_org) o_rd_data <= mem_r[i_rd_addr[3:0]];
            else o_rd_data <= {8'h00, byte_of(mem_r[i_rd_addr[4:1]], i_rd_addr[0])};
        end
    end

    // ==========================================================
    // checks
    AST_SELF_TIMED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $fell(o_busy) |-> run_len_r == CNT_W'(PROG_CYCLES))
        else $error("programming cycle length wrong");
    AST_WRITE_ONE_LOC: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_start && i_cmd.op == OP_WRITE && i_org
        |=> mem_r[$past(i_cmd.addr[3:0])] == $past(i_cmd.data))
        else $error("word write not stored");
    AST_NO_PRE_ERASE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_start && i_cmd.op == OP_WRITE && !i_org
        |=> byte_of(mem_r[$past(i_cmd.addr[4:1])], $past(i_cmd.addr[0]))
            == $past(i_cmd.data[7:0]))
        else $error("byte write not stored");

endmodule : sea_cell_array
`default_nettype wire

/* File: hw/sea_pkg.sv */
`default_nettype none
package sea_pkg;

    // ==========================================================
    // geometry
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 5;
    localparam int NUM_WORDS = 16;

    localparam logic [4:0]  OPC_LAST       = 5'h03;
    localparam logic [4:0]  ADDR_LAST_WORD = 5'h03;
    localparam logic [4:0]  ADDR_LAST_BYTE = 5'h04;
    localparam logic [4:0]  DATA_LAST_WORD = 5'h0F;
    localparam logic [4:0]  DATA_LAST_BYTE = 5'h07;
    localparam logic [3:0]  BITS_LAST_WORD = 4'hF;
    localparam logic [3:0]  BITS_LAST_BYTE = 4'h7;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;

    // ==========================================================
    // timing
    localparam int PROG_TIME_US    = 10000;
    localparam int CORE_CLK_MHZ    = 200;
    localparam int PROG_CYCLES_DEF = PROG_TIME_US * CORE_CLK_MHZ;

    // ==========================================================
    // instructions
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_ERASE,
        OP_UNLOCK,
        OP_LOCK,
        OP_ERASE_ALL,
        OP_FILL_ALL
    } sea_op_t;

    typedef enum logic [2:0] {
        LS_SKIP,
        LS_HUNT,
        LS_OPC,
        LS_ADDR,
        LS_DATA,
        LS_READ,
        LS_DONE
    } sea_link_st_t;

    typedef struct packed {
        sea_op_t                 op;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } sea_cmd_t;

    function automatic sea_op_t sea_decode(input logic [3:0] opc);
        sea_op_t op;
        op = OP_LOCK;
        if (opc[3:2] == 2'h2) op = OP_READ;
        else if (opc[3:2] == 2'h1) op = OP_WRITE;
        else if (opc[3:2] == 2'h3) op = OP_ERASE;
        else if (opc == 4'h3) op = OP_UNLOCK;
        else if (opc == 4'h2) op = OP_ERASE_ALL;
        else if (opc == 4'h1) op = OP_FILL_ALL;
        return op;
    endfunction : sea_decode

    // word mode keeps the top address bit clear so the pointer wraps at 15
    function automatic logic [ADDR_W-1:0] sea_next_addr(input logic [ADDR_W-1:0] a,
                                                        input logic org);
        return org ? {1'b0, a[3:0] + 4'h1} : a + 5'h01;
    endfunction : sea_next_addr

endpackage : sea_pkg
`default_nettype wire

/* File: hw/sea_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - array seen as 32 bytes or 16 words by width select
// - read loads given address into pointer for first location
// - pointer increments after each location; stream continues while select high
// - pointer wraps from highest location to zero without a gap
// - programming cycle timed internally, independent of serial clock
// - write needs no prior erase; old contents replaced
// - one write programs exactly one byte or word
// - busy or ready shown on output while select high after programming
// - instructions via serial input: read, write, erase, erase all, fill all
// - four-bit opcodes then four or five address bits
// - width select high means words, low means bytes
// - first clock after select ignored, then hunt for start bit one
// - read sends one zero then data msb first, no zero between
module sea_port
    import sea_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_link_clk,
    input  wire logic i_sel,
    input  wire logic i_sdi,
    input  wire logic i_org,
    output logic      o_sdo,
    output logic      o_sdo_oe
);
    // link side
    logic              rst_link_n_r;
    logic              org_m_r, org_l_r;
    sea_link_st_t      st_r;
    logic [4:0]        cnt_r;
    logic [15:0]       sh_in_r, sh_in_nxt, out_sh_r, ld_word;
    logic [3:0]        bit_cnt_r;
    logic              reading_r, q_bit_r, started_r;
    logic              cmd_tgl_r, rd_tgl_r;
    logic [ADDR_W-1:0] rd_ptr_r, addr_val;
    sea_cmd_t          link_cmd_r;
    logic [4:0]        addr_last, data_last;
    sea_op_t           op_now;
    logic              opc_done, addr_done, data_done, rd_start, word_load, cmd_fire;
    wire logic         frame_rst_n = i_sel & rst_link_n_r;
    // core side
    logic              sel_m_r, sel_s_r, sel_d_r, org_cm_r, org_cs_r;
    logic              cmd_m_r, cmd_s_r, cmd_d_r, rd_m_r, rd_s_r, rd_d_r;
    logic              rdg_m_r, rdg_s_r, qb_m_r, qb_s_r, st_m_r, st_s_r, st_d_r;
    logic              pend_r, prog_en_r, prog_start_r, status_r, busy;
    sea_cmd_t          cmd_cap_r;
    logic [DATA_W-1:0] rd_data;
    logic              sel_fall, cmd_seen, rd_seen;

    // ==========================================================
    // link decode
    always_comb begin
        addr_last = org_l_r ? ADDR_LAST_WORD : ADDR_LAST_BYTE;
        data_last = org_l_r ? DATA_LAST_WORD : DATA_LAST_BYTE;
        sh_in_nxt = {sh_in_r[14:0], i_sdi};
        op_now    = sea_decode(sh_in_nxt[3:0]);
        addr_val  = org_l_r ? {1'b0, sh_in_nxt[3:0]} : sh_in_nxt[4:0];
        opc_done  = (st_r == LS_OPC) && (cnt_r == OPC_LAST);
        addr_done = (st_r == LS_ADDR) && (cnt_r == addr_last);
        data_done = (st_r == LS_DATA) && (cnt_r == data_last);
        rd_start  = addr_done && (link_cmd_r.op == OP_READ);
        word_load = (st_r == LS_READ) && (bit_cnt_r == '0);
        // byte sits in the top half of the shifter
        ld_word   = org_l_r ? rd_data : {rd_data[7:0], 8'h00};
        cmd_fire  = data_done || (addr_done && link_cmd_r.op != OP_READ
                    && link_cmd_r.op != OP_WRITE && link_cmd_r.op != OP_FILL_ALL);
    end

    // ==========================================================
    // link frame state, cleared while select is low
    always_ff @(posedge i_link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            st_r      <= LS_SKIP;
            cnt_r     <= '0;
            sh_in_r   <= '0;
            reading_r <= 1'b0;
            q_bit_r   <= 1'b0;
            started_r <= 1'b0;
            bit_cnt_r <= '0;
            out_sh_r  <= '0;
        end else begin
            sh_in_r <= sh_in_nxt;
            unique case (st_r)
                LS_SKIP: st_r <= LS_HUNT;
                LS_HUNT: begin
                    if (i_sdi) begin
                        st_r      <= LS_OPC;
                        cnt_r     <= '0;
                        started_r <= 1'b1;
                    end
                end
                LS_OPC: begin
                    cnt_r <= opc_done ? 5'h00 : cnt_r + 5'h01;
                    if (opc_done) st_r <= LS_ADDR;
                end
                LS_ADDR: begin
                    cnt_r <= addr_done ? 5'h00 : cnt_r + 5'h01;
                    if (rd_start) begin
                        st_r      <= LS_READ;
                        reading_r <= 1'b1;
                        q_bit_r   <= 1'b0;
                        bit_cnt_r <= '0;
                    end else if (addr_done) begin
                        st_r <= cmd_fire ? LS_DONE : LS_DATA;
                    end
                end
                LS_DATA: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (data_done) st_r <= LS_DONE;
                end
                // msb first, no gap between locations
                LS_READ: begin
                    if (word_load) begin
                        q_bit_r   <= ld_word[15];
                        out_sh_r  <= {ld_word[14:0], 1'b0};
                        bit_cnt_r <= org_l_r ? BITS_LAST_WORD : BITS_LAST_BYTE;
                    end else begin
                        q_bit_r   <= out_sh_r[15];
                        out_sh_r  <= {out_sh_r[14:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r - 4'h1;
                    end
                end
                LS_DONE: begin
                end
            endcase
        end
    end

    // ==========================================================
    // link registers that must outlive the frame
    always_ff @(posedge i_link_clk or negedge rst_link_n_r) begin
        if (!rst_link_n_r) begin
            org_m_r <= 1'b1;
            org_l_r <= 1'b1;
        end else begin
            org_m_r <= i_org;
            org_l_r <= org_m_r;
        end
    end

    always_ff @(posedge i_link_clk or negedge rst_link_n_r) begin
        if (!rst_link_n_r) begin
            rd_ptr_r <= '0;
            rd_tgl_r <= 1'b0;
        end else if (rd_start) begin
            rd_ptr_r <= addr_val;
            rd_tgl_r <= ~rd_tgl_r;
        end else if (word_load) begin
            rd_ptr_r <= sea_next_addr(rd_ptr_r, org_l_r);
            rd_tgl_r <= ~rd_tgl_r;
        end
    end

    // command handed to the core domain
    always_ff @(posedge i_link_clk or negedge rst_link_n_r) begin
        if (!rst_link_n_r) begin
            link_cmd_r <= '{op: OP_LOCK, addr: '0, data: '0};
            cmd_tgl_r  <= 1'b0;
        end else begin
            if (opc_done) link_cmd_r.op <= op_now;
            if (addr_done) begin
                link_cmd_r.addr <= addr_val;
                link_cmd_r.data <= '0;
            end
            if (data_done) link_cmd_r.data <= org_l_r ? sh_in_nxt : {8'h00, sh_in_nxt[7:0]};
            if (cmd_fire) cmd_tgl_r <= ~cmd_tgl_r;
        end
    end

    // ==========================================================
    // core synchronisers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            {sel_m_r, sel_s_r, sel_d_r, org_cm_r, org_cs_r} <= 5'h03;
            {cmd_m_r, cmd_s_r, cmd_d_r, rd_m_r, rd_s_r, rd_d_r} <= 6'h00;
            {rdg_m_r, rdg_s_r, qb_m_r, qb_s_r, st_m_r, st_s_r, st_d_r} <= 7'h00;
            rst_link_n_r <= 1'b0;
        end else begin
            {sel_m_r, sel_s_r, sel_d_r} <= {i_sel, sel_m_r, sel_s_r};
            {org_cm_r, org_cs_r} <= {i_org, org_cm_r};
            {cmd_m_r, cmd_s_r, cmd_d_r} <= {cmd_tgl_r, cmd_m_r, cmd_s_r};
            {rd_m_r, rd_s_r, rd_d_r} <= {rd_tgl_r, rd_m_r, rd_s_r};
            {rdg_m_r, rdg_s_r, qb_m_r, qb_s_r} <= {reading_r, rdg_m_r, q_bit_r, qb_m_r};
            {st_m_r, st_s_r, st_d_r} <= {started_r, st_m_r, st_s_r};
            rst_link_n_r <= 1'b1;
        end
    end

    assign sel_fall = sel_d_r & ~sel_s_r;
    assign cmd_seen = cmd_s_r ^ cmd_d_r;
    assign rd_seen  = rd_s_r ^ rd_d_r;

    // ==========================================================
    // command execution at select fall
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pend_r    <= 1'b0;
            cmd_cap_r <= '{op: OP_LOCK, addr: '0, data: '0};
        end else if (cmd_seen && !busy) begin
            // link fields are stable once the toggle is seen
            pend_r    <= 1'b1;
            cmd_cap_r <= link_cmd_r;
        end else if (sel_fall || (sel_s_r && !sel_d_r)) begin
            pend_r <= 1'b0;
        end
    end

    // starts locked, as after power-up
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) prog_en_r <= 1'b0;
        else if (sel_fall && pend_r && cmd_cap_r.op == OP_UNLOCK) prog_en_r <= 1'b1;
        else if (sel_fall && pend_r && cmd_cap_r.op == OP_LOCK) prog_en_r <= 1'b0;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) prog_start_r <= 1'b0;
        else prog_start_r <= sel_fall && pend_r && prog_en_r && !busy
                             && cmd_cap_r.op != OP_UNLOCK && cmd_cap_r.op != OP_LOCK;
    end

    // ready stays visible until the next start bit; start set wins
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) status_r <= 1'b0;
        else if (prog_start_r) status_r <= 1'b1;
        else if (st_s_r && !st_d_r && !busy) status_r <= 1'b0;
    end

    sea_cell_array #(
        .PROG_CYCLES (PROG_CYCLES),
        .WORDS       (NUM_WORDS)
    ) u_cells (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_start    (prog_start_r),
        .i_cmd      (cmd_cap_r),
        .i_org      (org_cs_r),
        .i_rd_load  (rd_seen),
        .i_rd_addr  (rd_ptr_r),
        .o_rd_data  (rd_data),
        .o_busy     (busy)
    );
    // rd_data settles well inside one serial period before link reads it

    // ==========================================================
    // output pin
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdo_oe <= sel_s_r && (busy || rdg_s_r || status_r);
            o_sdo    <= busy ? 1'b0 : (rdg_s_r ? qb_s_r : 1'b1);
        end
    end

    // ==========================================================
    // checks
    AST_BUSY_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        sel_s_r && busy |=> o_sdo_oe && !o_sdo)
        else $error("busy not shown low");
    AST_READY_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        sel_s_r && !busy && !rdg_s_r && status_r |=> o_sdo_oe && o_sdo)
        else $error("ready not shown high");
    AST_LOCKED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !prog_en_r |=> !prog_start_r)
        else $error("program started while locked");
    AST_SKIP_FIRST: assert property (@(posedge i_link_clk) disable iff (!frame_rst_n)
        st_r == LS_SKIP |=> st_r == LS_HUNT && !started_r)
        else $error("first pulse not ignored");
    AST_DUMMY_ZERO: assert property (@(posedge i_link_clk) disable iff (!frame_rst_n)
        rd_start |=> reading_r && !q_bit_r ##1 q_bit_r == $past(ld_word[15]))
        else $error("leading zero or msb wrong");
    AST_PTR_LOAD: assert property (@(posedge i_link_clk) disable iff (!frame_rst_n)
        rd_start |=> rd_ptr_r == $past(addr_val) && rd_tgl_r != $past(rd_tgl_r))
        else $error("pointer not loaded");
    AST_PTR_STEP: assert property (@(posedge i_link_clk) disable iff (!frame_rst_n)
        word_load && org_l_r && rd_ptr_r != 5'h0F |=> rd_ptr_r == $past(rd_ptr_r) + 5'h01)
        else $error("pointer not incremented");
    AST_WRAP: assert property (@(posedge i_link_clk) disable iff (!frame_rst_n)
        word_load && org_l_r && rd_ptr_r[3:0] == 4'hF |=> rd_ptr_r == '0 ##1 st_r == LS_READ)
        else $error("pointer did not wrap");

    COV_READ_WRAP: cover property (@(posedge i_link_clk) word_load && rd_ptr_r == 5'h1F);
    COV_PROG: cover property (@(posedge i_core_clk) prog_start_r ##1 busy);
    COV_READY: cover property (@(posedge i_core_clk) o_sdo_oe && o_sdo && status_r && !busy);

endmodule : sea_port
`default_nettype wire

/* File: test/sea_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// host side of the serial link
module sea_host (
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output logic      o_sel,
    output logic      o_clk,
    output logic      o_sdi
);
    // two halves make a serial period just over 1 us, off the core clock's phase
    localparam time HALF = 501ns;
    wire logic pin;
    assign pin = i_sdo_oe ? i_sdo : 1'bz;
    initial begin
        o_sel = 1'b0;
        o_clk = 1'b0;
        o_sdi = 1'b1;
    end
    task automatic sel_set(input logic v);
        if (v) #300ns;
        o_sel = v;
        if (!v) o_sdi = ~o_sdi;
    endtask : sel_set
    task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                        output logic [63:0] rx);
        rx = '0;
        o_sdi = 1'b0;
        sel_set(1'b1);
        #HALF;
        for (int i = -1; i < ntx + nrx; i++) begin
            if (i >= 0 && i < ntx) o_sdi = tx[ntx-1-i];
            #HALF;
            if (i >= ntx) rx = {rx[62:0], pin};
            o_clk = 1'b1;
            #HALF o_clk = 1'b0;
        end
        #HALF sel_set(1'b0);
    endtask : xfer
endmodule : sea_host
`default_nettype wire

/* File: test/sea_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// bench
module sea_port_bench;
    import sea_pkg::*;
    localparam int unsigned PC = 400;
    logic        i_core_clk, i_rst_n, i_org, sel, lclk, sdi, sdo, oe;
    int          errors, total_checks, seed;
    logic [15:0] mem [16];
    logic [63:0] rx;
    logic [15:0] d;
    logic [4:0]  a;
    sea_port #(.PROG_CYCLES(PC)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_link_clk(lclk), .i_sel(sel), .i_sdi(sdi), .i_org(i_org), .o_sdo(sdo),
        .o_sdo_oe(oe));
    sea_host host (.i_sdo(sdo), .i_sdo_oe(oe), .o_sel(sel), .o_clk(lclk), .o_sdi(sdi));
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] loc(input logic [4:0] p);
        if (i_org) return mem[p[3:0]];
        return {8'h00, p[0] ? mem[p[4:1]][7:0] : mem[p[4:1]][15:8]};
    endfunction : loc
    // leading zero bit stays clear in the expected value
    function automatic logic [63:0] exp_rd(input logic [4:0] p, input int n);
        logic [63:0] e;
        e = '0;
        for (int k = 0; k < n; k++) begin
            e = (e << (i_org ? 16 : 8)) | 64'(loc(p));
            p = i_org ? 5'((p + 1) % 16) : 5'(p + 1);
        end
        return e;
    endfunction : exp_rd
    task automatic cmd(input logic [3:0] op, input logic [4:0] p, input logic [15:0] v,
                       input int nrx);
        int na, nd;
        logic [63:0] tx;
        na = i_org ? 4 : 5;
        nd = (op[3:2] == 2'h1 || op == 4'h1) ? (i_org ? 16 : 8) : 0;
        tx = (64'h1F & {60'h1, op}) << na | 64'(p);
        tx = (tx << nd) | 64'(v);
        host.xfer(tx, 5 + na + nd, nrx, rx);
    endtask : cmd
    task automatic rd(input logic [4:0] p, input int n);
        cmd(4'h8 | 4'($random(seed) & 3), p, 16'h0000, 1 + n * (i_org ? 16 : 8));
        chk("read", exp_rd(p, n), rx);
    endtask : rd
    task automatic prog_wait(input logic busy);
        int n;
        n = 0;
        host.sel_set(1'b1);
        repeat (8) @(posedge i_core_clk);
        // look after the edge so the output flop has settled
        #1;
        chk("busy", busy ? 1'b0 : 1'bz, host.pin);
        while (busy && host.pin !== 1'b1 && n < PC + 100) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (busy) chk("ready", 1'b1, host.pin);
        if (busy) chk("prog_len", 1'b1, n > PC - 80 && n < PC - 50);
        host.sel_set(1'b0);
    endtask : prog_wait
    initial begin
        seed = 32'h0891;
        errors = 0;
        total_checks = 0;
        i_rst_n = 1'b0;
        i_org = 1'b1;
        repeat (12) @(posedge i_core_clk);
        #1 i_rst_n = 1'b1;
        repeat (6) @(posedge i_core_clk);
        cmd(4'h3, 5'h00, 16'h0000, 0);
        d = 16'($random(seed));
        cmd(4'h1, 5'h00, d, 0);
        prog_wait(1'b1);
        foreach (mem[i]) mem[i] = d;
        a = 5'($random(seed) & 15);
        d = 16'($random(seed));
        cmd(4'h4 | 4'($random(seed) & 3), a, d, 0);
        prog_wait(1'b1);
        mem[a[3:0]] = d;
        rd(a, 2);
        rd(5'h0F, 2);
        $display("word write and read done");
        cmd(4'hC | 4'($random(seed) & 3), a, 16'h0000, 0);
        prog_wait(1'b1);
        mem[a[3:0]] = ERASED_WORD;
        rd(a, 1);
        cmd(4'h0, 5'h00, 16'h0000, 0);
        cmd(4'h4, a, 16'h1234, 0);
        prog_wait(1'b0);
        rd(a, 1);
        $display("erase and lock done");
        cmd(4'h3, 5'h00, 16'h0000, 0);
        cmd(4'h2, 5'h00, 16'h0000, 0);
        prog_wait(1'b1);
        foreach (mem[i]) mem[i] = ERASED_WORD;
        rd(5'h0A, 2);
        @(posedge i_core_clk);
        #1 i_org = 1'b0;
        for (int t = 0; t < 2; t++) begin
            a = t == 0 ? 5'h1F : 5'($random(seed));
            d = 16'($random(seed) & 16'h00FF);
            cmd(4'h4, a, d, 0);
            prog_wait(1'b1);
            if (a[0]) mem[a[4:1]][7:0] = d[7:0];
            else mem[a[4:1]][15:8] = d[7:0];
            rd(a, 2);
            rd(a ^ 5'h01, 1);
        end
        $display("byte mode done");
        close_out();
    end
endmodule : sea_port_bench
`default_nettype wire
